// ### design/perm_decode.v
`timescale 1ns/1ps
`include "stack_guard_defines.vh"

// Classifies one stage's leaf permission bits
module perm_decode #(
  parameter STACK_CAPABLE = 1
) (
  // Permission bits and enable
  input wire [2:0] perm_in,
  input wire stack_enable_in,
  // Classification
  output wire is_stack_page_out,
  output wire is_read_only_out,
  output wire is_reserved_out
);

  // Write-only code seen on this stage, whether or not it can carry stack pages
  wire write_only_code;
  // Write-only code names a stack page only where enabled
  wire stack_code;

  assign write_only_code = (perm_in == `PERM_STACK_PAGE);
  assign stack_code = (STACK_CAPABLE != 0) && stack_enable_in && write_only_code;

  // Stack page output
  assign is_stack_page_out = stack_code;
  // Read-only page output
  assign is_read_only_out = (perm_in == `PERM_READ_ONLY);
  // Write without read stays reserved unless it is a stack page
  assign is_reserved_out = perm_in[`PERM_W] && !perm_in[`PERM_R] && !stack_code;

endmodule // perm_decode

// ### design/shadow_stack_page_guard.v
`timescale 1ns/1ps
`include "stack_guard_defines.vh"

// Behaviour
// - Write-only first-stage code marks a stack page
// - Write-only code reserved while machine enable clear
// - Bare translation below machine: stack accesses fault
// - Machine-mode atomic swap always access faults
// - Other writes to stack pages access fault
// - Cache-block operations on stack pages fault
// - Implicit accesses fault with matching access type
// - Plain loads may read stack pages
// - Executable-readable setting ignored for stack pages
// - Stack instruction faults use store causes
// - Stack instructions need stack or read-only page
// - Read-only page gives store page fault
// - Writable or executable pages give access fault
// - Misaligned stack pointer on push or pop-check gives access fault
// - Stack accesses require idempotent memory
// - User and supervisor-user checks apply normally
// - Second-stage write-only code stays reserved
// - Second stage needs read-write else guest fault
// - Memory guard must grant read and write
// - Atomic swap needs swap-capable memory
// - Memory-type and contiguity hints pass unchanged
// - Enable changes act at once, nothing cached
module shadow_stack_page_guard (
  // Clock and reset
  input wire clk_sys_in,
  input wire rstn_in,
  // Access request
  input wire access_valid_in,
  input wire [2:0] access_kind_in,
  input wire [1:0] priv_in,
  input wire virt_in,
  input wire stack_misaligned_in,
  // Translation state
  input wire translation_bare_in,
  input wire machine_stack_protect_enable_in,
  input wire make_executable_readable_in,
  input wire supervisor_user_memory_access_in,
  // First-stage leaf entry
  input wire [2:0] leaf_perm_in,
  input wire leaf_user_in,
  input wire [1:0] leaf_mem_type_in,
  input wire leaf_contig_hint_in,
  // Second-stage leaf entry
  input wire g_stage_active_in,
  input wire [2:0] g_leaf_perm_in,
  input wire g_leaf_user_in,
  // Physical checks
  input wire physical_memory_guard_read_in,
  input wire physical_memory_guard_write_in,
  input wire physical_memory_guard_exec_in,
  input wire physical_memory_attributes_idempotent_in,
  input wire physical_memory_attributes_swap_in,
  // Check result
  output reg check_valid_out,
  output reg fault_out,
  output reg [4:0] cause_out,
  output reg stack_page_out,
  output reg [1:0] mem_type_out,
  output reg contig_hint_out
);

  // First-stage classification
  wire leaf_is_stack;
  wire leaf_is_read_only;
  wire leaf_is_reserved;
  // Second-stage classification, only the reserved flag is needed
  wire g_is_reserved;

  // Kind decode
  reg is_stack_insn; // Push, pop-check or atomic swap
  reg is_swap; // Stack atomic swap alone
  reg is_plain_write; // Ordinary store or atomic
  reg is_cbo; // Cache-block operation
  reg is_fetch; // Instruction fetch
  reg is_load; // Ordinary load
  // Permission outcomes
  reg below_machine; // Effective privilege below machine
  reg paged; // First-stage translation applies
  reg user_ok; // User bit and supervisor-user checks pass
  reg g_ok; // Second stage grants the access
  reg guard_ok; // Memory guard grants the access
  // First-stage grants for an ordinary page
  reg leaf_read_ok; // Readable, or executable with executable-readable set
  reg leaf_write_ok; // Writable
  reg leaf_exec_ok; // Executable
  reg leaf_grant; // Grant for the kind at hand
  // Next values of the result registers
  reg next_fault;
  reg [4:0] next_cause;

  // First stage may hold stack pages, enable read live each access
  perm_decode #(
    .STACK_CAPABLE(1)
  ) u_leaf_decode (
    .perm_in(leaf_perm_in),
    .stack_enable_in(machine_stack_protect_enable_in),
    .is_stack_page_out(leaf_is_stack),
    .is_read_only_out(leaf_is_read_only),
    .is_reserved_out(leaf_is_reserved)
  );

  // Second stage never carries stack pages
  perm_decode #(
    .STACK_CAPABLE(0)
  ) u_g_decode (
    .perm_in(g_leaf_perm_in),
    // Enable held low, so write-only code stays reserved here
    .stack_enable_in(1'b0),
    .is_stack_page_out(),
    .is_read_only_out(),
    .is_reserved_out(g_is_reserved)
  );

  // Access kind decode, compressed forms share the plain kind codes
  always @* begin
    // Stack instructions, whatever they do to memory
    is_stack_insn = (access_kind_in == `KIND_STACK_PUSH) ||
                    (access_kind_in == `KIND_STACK_POP_CHECK) ||
                    (access_kind_in == `KIND_STACK_ATOMIC_SWAP);
    // Swap has extra privilege and attribute checks
    is_swap = (access_kind_in == `KIND_STACK_ATOMIC_SWAP);
    // Ordinary stores and atomics count as writes
    is_plain_write = (access_kind_in == `KIND_STORE) || (access_kind_in == `KIND_AMO);
    // Cache-block operations are checked as writes
    is_cbo = (access_kind_in == `KIND_CBO);
    // Fetch is the only implicit access kind seen here
    is_fetch = (access_kind_in == `KIND_FETCH);
    // Plain load, the only non-stack kind allowed to read a stack page
    is_load = (access_kind_in == `KIND_LOAD);
  end

  // Privilege, translation and permission outcomes
  always @* begin
    // Effective privilege decides whether translation applies
    below_machine = (priv_in != `PRIV_MACHINE);
    // Machine mode behaves as untranslated
    paged = below_machine && !translation_bare_in;
    // User bit and supervisor-user access, same for stack accesses
    if (priv_in == `PRIV_USER) begin
      // User level may only touch user pages
      user_ok = leaf_user_in;
    end else if (leaf_user_in) begin
      // Supervisor reaches user pages only with the access flag, never to fetch
      user_ok = supervisor_user_memory_access_in && !is_fetch;
    end else begin
      // Supervisor page seen from supervisor level
      user_ok = 1'b1;
    end
    // Second stage, applied only when active
    if (!g_stage_active_in) begin
      // No second stage, nothing to refuse
      g_ok = 1'b1;
    end else if (!g_leaf_user_in || g_is_reserved) begin
      // Guest accesses need user pages, write-only code stays reserved
      g_ok = 1'b0;
    end else if (is_stack_insn) begin
      // Stack instructions need read and write in the second stage
      g_ok = g_leaf_perm_in[`PERM_R] && g_leaf_perm_in[`PERM_W];
    end else if (is_fetch) begin
      // Fetch needs execute
      g_ok = g_leaf_perm_in[`PERM_X];
    end else if (is_load) begin
      // Load may use executable pages when executable-readable is set
      g_ok = g_leaf_perm_in[`PERM_R] ||
             (make_executable_readable_in && g_leaf_perm_in[`PERM_X]);
    end else begin
      // Stores, atomics and cache-block operations need write
      g_ok = g_leaf_perm_in[`PERM_W];
    end
    // Memory guard per kind
    if (is_stack_insn) begin
      // Stack instructions need both read and write granted
      guard_ok = physical_memory_guard_read_in && physical_memory_guard_write_in;
    end else if (is_fetch) begin
      // Fetch needs execute granted
      guard_ok = physical_memory_guard_exec_in;
    end else if (is_load) begin
      // Load needs read granted
      guard_ok = physical_memory_guard_read_in;
    end else begin
      // Everything else is a write
      guard_ok = physical_memory_guard_write_in;
    end
    // First-stage grants, used for ordinary pages only
    leaf_read_ok = leaf_perm_in[`PERM_R] ||
                   (make_executable_readable_in && leaf_perm_in[`PERM_X]);
    leaf_write_ok = leaf_perm_in[`PERM_W];
    leaf_exec_ok = leaf_perm_in[`PERM_X];
    // Pick the grant that matches the access kind
    if (is_fetch) begin
      // Fetch needs execute
      leaf_grant = leaf_exec_ok;
    end else if (is_load) begin
      // Load needs read
      leaf_grant = leaf_read_ok;
    end else begin
      // Stores, atomics and cache-block operations need write
      leaf_grant = leaf_write_ok;
    end
  end

  // Fault selection in priority order
  // Stack instructions first, then ordinary accesses to stack pages, then the rest
  always @* begin
    // No fault unless a check below refuses the access
    next_fault = 1'b0;
    next_cause = `RESET_CAUSE;
    if (is_stack_insn) begin
      // All stack faults are reported as store kind
      // Checks run from alignment, privilege and bare translation to page, second-stage, then memory checks
      if (stack_misaligned_in && !is_swap) begin
        // Refused outright so that no handler emulates the access
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (is_swap && !below_machine) begin
        // Machine level has no stack pages for a swap to use
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (!paged) begin
        // Bare translation below machine forbids stack accesses
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (leaf_is_read_only || leaf_is_reserved || !user_ok) begin
        // Read-only page lets the handler copy on write
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_PAGE;
      end else if (!leaf_is_stack) begin
        // Any other valid page is a fatal mismatch
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (!g_ok) begin
        // Second stage lacks read and write
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_GUEST;
      end else if (!guard_ok || !physical_memory_attributes_idempotent_in) begin
        // Guard without read and write, or memory with side effects on read
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (is_swap && !physical_memory_attributes_swap_in) begin
        // Memory that cannot swap atomically
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end
    end else if (paged && leaf_is_stack) begin
      // Ordinary access landing on a stack page
      if (is_plain_write || is_cbo) begin
        // Fatal, so an access fault rather than a page fault
        next_fault = 1'b1;
        next_cause = `CAUSE_STORE_ACCESS;
      end else if (is_fetch) begin
        // Implicit fetch refused with its own access type
        next_fault = 1'b1;
        next_cause = `CAUSE_FETCH_ACCESS;
      end else if (!user_ok) begin
        // Load still subject to the user checks
        next_fault = 1'b1;
        next_cause = `CAUSE_LOAD_PAGE;
      end else if (!g_ok) begin
        // Load refused by the second stage
        next_fault = 1'b1;
        next_cause = `CAUSE_LOAD_GUEST;
      end else if (!guard_ok) begin
        // Load refused by the memory guard
        next_fault = 1'b1;
        next_cause = `CAUSE_LOAD_ACCESS;
      end
      // Otherwise a load reads it, executable-readable not consulted
    end else begin
      // Ordinary access to an ordinary page
      if (paged && (leaf_is_reserved || !user_ok || !leaf_grant)) begin
        // First stage refuses, reported as a page fault of the access type
        next_fault = 1'b1;
        if (is_fetch) begin
          next_cause = `CAUSE_FETCH_PAGE;
        end else if (is_load) begin
          next_cause = `CAUSE_LOAD_PAGE;
        end else begin
          // Stores, atomics and cache-block operations
          next_cause = `CAUSE_STORE_PAGE;
        end
      end else if (!g_ok) begin
        // Second stage refuses
        next_fault = 1'b1;
        if (is_fetch) begin
          next_cause = `CAUSE_FETCH_GUEST;
        end else if (is_load) begin
          next_cause = `CAUSE_LOAD_GUEST;
        end else begin
          // Stores, atomics and cache-block operations
          next_cause = `CAUSE_STORE_GUEST;
        end
      end else if (!guard_ok) begin
        // Memory guard refuses
        next_fault = 1'b1;
        if (is_fetch) begin
          next_cause = `CAUSE_FETCH_ACCESS;
        end else if (is_load) begin
          next_cause = `CAUSE_LOAD_ACCESS;
        end else begin
          // Stores, atomics and cache-block operations
          next_cause = `CAUSE_STORE_ACCESS;
        end
      end
    end
  end

  // Result registers, one cycle after the request
  // Every edge takes a fresh decision, nothing is held between requests
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // All results clear while in reset
      check_valid_out <= 1'b0;
      fault_out <= 1'b0;
      cause_out <= `RESET_CAUSE;
      stack_page_out <= 1'b0;
      mem_type_out <= `RESET_HINT;
      contig_hint_out <= 1'b0;
    end else begin
      // Valid follows the request one cycle late
      check_valid_out <= access_valid_in;
      // Results only meaningful with a valid request
      if (access_valid_in) begin
        fault_out <= next_fault;
        cause_out <= next_cause;
        stack_page_out <= paged && leaf_is_stack;
        // Hint fields pass untouched to the memory system
        mem_type_out <= leaf_mem_type_in;
        contig_hint_out <= leaf_contig_hint_in;
      end else begin
        // Idle cycles show zeros so a stale result never looks current
        fault_out <= 1'b0;
        cause_out <= `RESET_CAUSE;
        stack_page_out <= 1'b0;
        mem_type_out <= `RESET_HINT;
        contig_hint_out <= 1'b0;
      end
    end
  end

endmodule // shadow_stack_page_guard

// ### pkg/stack_guard_defines.vh
`ifndef STACK_GUARD_DEFINES_VH
`define STACK_GUARD_DEFINES_VH

// Access kinds presented by the load/store pipeline
`define KIND_LOAD 3'h0
`define KIND_STORE 3'h1
`define KIND_AMO 3'h2
`define KIND_CBO 3'h3
`define KIND_FETCH 3'h4
`define KIND_STACK_PUSH 3'h5
`define KIND_STACK_POP_CHECK 3'h6
`define KIND_STACK_ATOMIC_SWAP 3'h7

// Effective privilege encodings
`define PRIV_USER 2'h0
`define PRIV_SUPER 2'h1
`define PRIV_MACHINE 2'h3

// Field positions of the three permission bits
`define PERM_R 0
`define PERM_W 1
`define PERM_X 2

// Permission encodings of interest (x,w,r)
`define PERM_STACK_PAGE 3'h2
`define PERM_READ_ONLY 3'h1

// Exception cause codes
`define CAUSE_FETCH_ACCESS 5'h01
`define CAUSE_LOAD_ACCESS 5'h05
`define CAUSE_STORE_ACCESS 5'h07
`define CAUSE_FETCH_PAGE 5'h0c
`define CAUSE_LOAD_PAGE 5'h0d
`define CAUSE_STORE_PAGE 5'h0f
`define CAUSE_FETCH_GUEST 5'h14
`define CAUSE_LOAD_GUEST 5'h15
`define CAUSE_STORE_GUEST 5'h17

// Reset values of the result registers
`define RESET_CAUSE 5'h00
`define RESET_HINT 2'h0

`endif

// ### sim/pipeline_model.sv
`timescale 1ns/1ps
// Load/store pipeline: presents one access for each command
module pipeline_model (
  // Command from the bench
  input wire go_in,
  input wire [24:0] cmd_in,
  // Request to the guard
  output wire access_valid_out,
  output wire [24:0] req_out
);
  // Released fields show the inverse, so a stale value never looks held
  assign req_out = go_in ? cmd_in : ~cmd_in;
  assign access_valid_out = go_in;
endmodule // pipeline_model

// ### sim/shadow_stack_page_guard_monitor.sv
`timescale 1ns/1ps
// Watches the guard's ports and checks each access decision one edge later
module shadow_stack_page_guard_monitor (
  // Clock, reset and request
  input wire clk_sys_in, rstn_in, access_valid_in,
  input wire [2:0] access_kind_in,
  input wire [1:0] priv_in,
  input wire stack_misaligned_in, translation_bare_in,
  input wire machine_stack_protect_enable_in,
  // Leaf entries and physical checks
  input wire [2:0] leaf_perm_in, g_leaf_perm_in,
  input wire leaf_user_in, g_stage_active_in, leaf_contig_hint_in,
  input wire [1:0] leaf_mem_type_in,
  input wire physical_memory_guard_read_in,
  // Result
  input wire check_valid_out, fault_out, stack_page_out, contig_hint_out,
  input wire [4:0] cause_out,
  input wire [1:0] mem_type_out
);
  // Translated access below machine level
  wire paged = priv_in != 2'h3 && !translation_bare_in;
  // Access lands on an enabled stack page
  wire hit = paged && machine_stack_protect_enable_in && leaf_perm_in == 3'h2;
  // Stack instruction request
  wire stk = access_valid_in && access_kind_in[2] && access_kind_in[1:0] != 2'h0;
  // User bit suits the privilege
  wire uok = leaf_user_in == (priv_in == 2'h0);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_answer_next_edge: assert property (access_valid_in |=> check_valid_out)
    else $error("request not answered on next edge");
  a_bare_stack_fault: assert property (stk && translation_bare_in && priv_in != 2'h3 |=>
    fault_out && cause_out == 5'h07) else $error("bare stack access not refused");
  a_machine_swap_fault: assert property (access_valid_in && access_kind_in == 3'h7 &&
    priv_in == 2'h3 |=> fault_out && cause_out == 5'h07) else $error("machine swap allowed");
  a_write_stack_page: assert property (access_valid_in && hit &&
    access_kind_in inside {3'h1, 3'h2, 3'h3} |=> cause_out == 5'h07 && stack_page_out)
    else $error("write to stack page not refused");
  a_fetch_stack_page: assert property (access_valid_in && hit && access_kind_in == 3'h4
    |=> cause_out == 5'h01) else $error("fetch from stack page not refused");
  a_load_stack_page: assert property (access_valid_in && hit && access_kind_in == 3'h0 &&
    uok && !g_stage_active_in && physical_memory_guard_read_in |=> !fault_out && stack_page_out)
    else $error("load from stack page refused");
  a_misaligned_stack: assert property (stk && access_kind_in != 3'h7 && stack_misaligned_in
    |=> cause_out == 5'h07) else $error("misaligned stack access cause wrong");
  a_read_only_page: assert property (stk && paged && !stack_misaligned_in &&
    leaf_perm_in == 3'h1 |=> cause_out == 5'h0f) else $error("read-only page cause wrong");
  a_guest_stage_fault: assert property (stk && hit && uok && !stack_misaligned_in &&
    g_stage_active_in && g_leaf_perm_in[1:0] != 2'h3 |=> cause_out == 5'h17)
    else $error("second stage without read-write allowed");
  a_store_type_causes: assert property (check_valid_out && fault_out && $past(stk) |->
    cause_out inside {5'h07, 5'h0f, 5'h17}) else $error("stack fault not of store type");
  a_hint_copy: assert property (access_valid_in |=> mem_type_out == $past(leaf_mem_type_in)
    && contig_hint_out == $past(leaf_contig_hint_in)) else $error("hints not passed on");
  a_reserved_page: assert property (access_valid_in && access_kind_in == 3'h0 && paged &&
    !machine_stack_protect_enable_in && leaf_perm_in == 3'h2 |=> cause_out == 5'h0d &&
    !stack_page_out) else $error("write-only code not reserved");
endmodule // shadow_stack_page_guard_monitor

bind shadow_stack_page_guard shadow_stack_page_guard_monitor i_mon (.*);

// ### sim/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the stack page guard
module testbench;
  reg clk_sys_in = 1'b0; // Core clock
  reg rstn_in = 1'b0; // Reset, active low
  reg go = 1'b0; // Request strobe
  reg [24:0] cmd = 25'h0; // Request fields
  wire v; // Valid towards the guard
  wire [24:0] r; // Fields towards the guard
  wire cv, f, sp, ch; // Result flags
  wire [4:0] ca; // Cause code
  wire [1:0] mt; // Memory type copy
  integer mismatches = 0;
  integer n_checks = 0;
  integer i;
  localparam [24:0] B = 25'h0f614d; // Supervisor push to a stack page
  localparam [24:0] SSE = 25'h40, BARE = 25'h20, MIS = 25'h800, GA = 25'h1000;
  localparam [24:0] PR = 25'h10000, PW = 25'h20000, ID = 25'h40000, SW = 25'h80000;
  localparam [24:0] MAKE_EXECUTABLE_READABLE = 25'h100000, USR = 25'h400, HNT = 25'h1c00000;
  // 50 MHz clock
  always #10 clk_sys_in = ~clk_sys_in;
  pipeline_model i_pipe (.go_in(go), .cmd_in(cmd), .access_valid_out(v), .req_out(r));
  shadow_stack_page_guard i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .access_valid_in(v), .access_kind_in(r[2:0]), .priv_in(r[4:3]), .virt_in(r[12]),
    .stack_misaligned_in(r[11]), .translation_bare_in(r[5]),
    .machine_stack_protect_enable_in(r[6]), .make_executable_readable_in(r[20]),
    .supervisor_user_memory_access_in(r[21]), .leaf_perm_in(r[9:7]), .leaf_user_in(r[10]),
    .leaf_mem_type_in(r[23:22]), .leaf_contig_hint_in(r[24]), .g_stage_active_in(r[12]),
    .g_leaf_perm_in(r[15:13]), .g_leaf_user_in(1'b1),
    .physical_memory_guard_read_in(r[16]), .physical_memory_guard_write_in(r[17]),
    .physical_memory_guard_exec_in(1'b1), .physical_memory_attributes_idempotent_in(r[18]),
    .physical_memory_attributes_swap_in(r[19]), .check_valid_out(cv), .fault_out(f),
    .cause_out(ca), .stack_page_out(sp), .mem_type_out(mt), .contig_hint_out(ch));
  // Replaces a three-bit field of a command
  function [24:0] s3(input [24:0] c, input integer lo, input [2:0] x);
    begin
      s3 = c;
      s3[lo +: 3] = x;
    end
  endfunction
  // Compares one value and counts it
  task cmp(input [4:0] s, input [4:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
    end
  endtask
  // Presents one access and checks the answer one edge later
  task go1(input [24:0] c, input ef, input [4:0] ec);
    begin
      @(posedge clk_sys_in);
      #1 go = 1'b1;
      cmd = c;
      @(posedge clk_sys_in);
      #1 go = 1'b0;
      cmp({4'h0, cv}, 5'h01);
      cmp({4'h0, f}, {4'h0, ef});
      cmp(ca, ec);
      cmp({4'h0, sp}, {4'h0, c[6] && c[4:3] != 2'h3 && !c[5] && c[9:7] == 3'h2});
      cmp({2'h0, ch, mt}, {2'h0, c[24:22]});
      $display("test done at %0t", $time);
    end
  endtask
  // Prints the counts and the verdict, then ends the run
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Cuts a hung run short
  initial begin
    #100000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    cmp({4'h0, cv}, 5'h00);
    go1(B, 1'b0, 5'h00);
    go1(s3(B, 0, 3'h6), 1'b0, 5'h00);
    go1(s3(B, 0, 3'h7), 1'b0, 5'h00);
    for (i = 5; i < 8; i = i + 1) go1(s3(s3(B, 0, i[2:0]), 7, 3'h1), 1'b1, 5'h0f);
    for (i = 3; i < 8; i = i + 1) if (i != 6) go1(s3(B, 7, i[2:0]), 1'b1, 5'h07);
    go1(B, 1'b0, 5'h00);
    go1(B ^ SSE, 1'b1, 5'h0f);
    go1(s3(B ^ SSE, 0, 3'h0), 1'b1, 5'h0d);
    go1(B | BARE, 1'b1, 5'h07);
    go1(s3(B | 25'h10, 0, 3'h7), 1'b1, 5'h07);
    for (i = 1; i < 4; i = i + 1) go1(s3(B, 0, i[2:0]), 1'b1, 5'h07);
    go1(s3(B, 0, 3'h4), 1'b1, 5'h01);
    go1(s3(B, 0, 3'h0), 1'b0, 5'h00);
    go1(s3(B ^ MAKE_EXECUTABLE_READABLE, 0, 3'h0), 1'b0, 5'h00);
    go1(B ^ MIS, 1'b1, 5'h07);
    go1(s3(B ^ MIS, 0, 3'h6), 1'b1, 5'h07);
    go1(B ^ ID, 1'b1, 5'h07);
    go1(s3(B ^ ID, 0, 3'h7), 1'b1, 5'h07);
    go1(B ^ USR, 1'b1, 5'h0f);
    go1(B ^ 25'h08, 1'b1, 5'h0f);
    go1(B ^ 25'h08 ^ USR, 1'b0, 5'h00);
    go1(B ^ GA, 1'b0, 5'h00);
    go1(s3(B ^ GA, 13, 3'h1), 1'b1, 5'h17);
    go1(s3(B ^ GA, 13, 3'h2), 1'b1, 5'h17);
    go1(s3(s3(B ^ GA, 13, 3'h2), 0, 3'h0), 1'b1, 5'h15);
    go1(B ^ PR, 1'b1, 5'h07);
    go1(B ^ PW, 1'b1, 5'h07);
    go1(s3(B ^ SW, 0, 3'h7), 1'b1, 5'h07);
    go1(B ^ SW ^ HNT, 1'b0, 5'h00);
    report_and_stop;
  end
endmodule // testbench
